// ==== shared/dvg_pkg.sv ====
package dvg_pkg;
    // ------------------------------------------------------------
    // address map, top nibble of the strobe-1 region
    // ------------------------------------------------------------
    localparam logic [3:0] NIB_SRAM = 4'h8;
    localparam logic [3:0] NIB_ROM = 4'hC;
    localparam logic [3:0] NIB_VME = 4'hD;
    localparam logic [3:0] NIB_REGS = 4'hF;
    localparam logic [31:0] VME_A24_BASE = 32'hD000_0000;
    localparam logic [31:0] ADDR_CTL_REG_BASE = 32'hFFFD_0000;
    localparam logic [31:0] IF_CTL_REG_BASE = 32'hFFFC_0000;
    // ------------------------------------------------------------
    // status codes
    // ------------------------------------------------------------
    localparam logic [1:0] STAT_RD_HI = 2'h2;
    localparam logic [3:0] STAT_WR_A = 4'hD;
    localparam logic [3:0] STAT_WR_B = 4'hE;
    // supervisory data function code
    localparam logic [2:0] FC_SUPER_DATA = 3'h5;
    // boot rom access: wait cycles before ready (150 ns parts)
    localparam int ROM_ACCESS_NS = 150;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ROM_WAIT_CYC = (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] ROM_WAIT_LAST = 5'(ROM_WAIT_CYC - 1);

    typedef enum logic [2:0] {
        DVG_IDLE = 3'b000,
        DVG_MST_ARM = 3'b001,
        DVG_MST_WAIT = 3'b010,
        DVG_REG_WAIT = 3'b011,
        DVG_ROM_WAIT = 3'b100,
        DVG_RDY = 3'b101,
        DVG_SLV_SEIZE = 3'b110,
        DVG_SLV_GRANT = 3'b111
    } dvg_state_t;

    // decoder outputs, all active low
    typedef struct packed {
        logic mst_wr_n;
        logic mst_rd_n;
        logic reg_wr_n;
        logic reg_rd_n;
        logic boot_rom_read_sel_n;
    } dvg_dec_t;

    // sequencer outputs, all active low
    typedef struct packed {
        logic gbus_en_n;
        logic mst_oe_n;
        logic slv_oe_n;
        logic lb_grant_n;
        logic dsp_ready_out_n;
    } dvg_ctl_t;

    typedef struct packed {
        dvg_dec_t dec;
        dvg_ctl_t ctl;
        dvg_state_t st;
        logic [4:0] cnt;
        logic ph1_q;
        logic ph3_q;
        logic [2:0] fc;
        logic slv_strobe_n;
        logic slv_rd_wr;
        logic slv_ack_n;
    } dvg_state_all_t;
endpackage

// ==== testbench/dvg_bus_glue_chk.sv ====
`timescale 1ns/1ps
module dvg_chk (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic dsp_clock_phase1_i,
    input wire logic [3:0] gstat_i,
    input wire logic [2:0] gaddr_hi_i,
    input wire logic global_strobe_upper_n_i,
    input wire logic lbr_n_i,
    input wire logic [4:0] dec_o,
    input wire logic [4:0] ctl_o,
    input wire logic [2:0] fc_o,
    input wire logic shared_sram_strobe_n_o,
    input wire logic addr_ctl_ack_oe_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic rise;
    assign rise = dsp_clock_phase1_i && !global_strobe_upper_n_i;
    a_reset_idle: assert property (
        $rose(rst_n_i) |-> dec_o == 5'h1F && ctl_o == 5'h07) else $error("bad reset");
    a_dec_mrd: assert property (
        $rose(dsp_clock_phase1_i) && $past(rst_n_i) && rise && gaddr_hi_i == 3'h5
        && gstat_i[3:2] == 2'h2 |-> ##2 dec_o == 5'h17) else $error("master read missed");
    a_dec_rwr: assert property (
        $rose(dsp_clock_phase1_i) && $past(rst_n_i) && rise && gaddr_hi_i == 3'h7
        && (gstat_i == 4'hD || gstat_i == 4'hE) |-> ##2 dec_o == 5'h1B) else $error("reg write missed");
    a_dec_rom: assert property (
        $rose(dsp_clock_phase1_i) && $past(rst_n_i) && rise && gaddr_hi_i == 3'h4
        && gstat_i[3:2] == 2'h2 |-> ##2 dec_o == 5'h1E) else $error("rom read missed");
    a_dec_strobe: assert property (
        $rose(dsp_clock_phase1_i) && $past(rst_n_i) && global_strobe_upper_n_i
        |-> ##2 dec_o == 5'h1F) else $error("decode without strobe");
    a_dec_single: assert property ($onehot0(~dec_o)) else $error("two decodes");
    a_grant_order: assert property (
        $fell(ctl_o[1]) |-> ctl_o[4:2] == 3'b110 && !$past(ctl_o[2])) else $error("grant out of order");
    a_ready_pulse: assert property (
        $fell(ctl_o[0]) |-> (!ctl_o[0]) [*3] ##[1:3] ctl_o[0]) else $error("ready width");
    a_ready_idle: assert property ($rose(ctl_o[0]) |-> ctl_o == 5'h07) else $error("not idle after ready");
    a_slave_end: assert property ($rose(lbr_n_i) |-> ##[1:16] ctl_o == 5'h07) else $error("slave not ended");
    a_fc_super: assert property (
        fc_o != 3'h0 |-> fc_o == dvg_pkg::FC_SUPER_DATA && ctl_o[2]) else $error("bad function code");
    a_sram_grant: assert property (!shared_sram_strobe_n_o |-> !ctl_o[1]) else $error("sram without grant");
    a_ack_float: assert property (
        !ctl_o[1] |-> !addr_ctl_ack_oe_o && ctl_o[4:3] == 2'b11) else $error("acks not floated");
    cover property ($fell(ctl_o[1]));
    cover property ($fell(ctl_o[0]) && fc_o == dvg_pkg::FC_SUPER_DATA);
    cover property ($fell(shared_sram_strobe_n_o));
endmodule
bind dvg_bus_glue dvg_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .dsp_clock_phase1_i(dsp_clock_phase1_i),
    .gstat_i(gstat_i), .gaddr_hi_i(gaddr_hi_i), .global_strobe_upper_n_i(global_strobe_upper_n_i), .lbr_n_i(lbr_n_i),
    .dec_o(dec_o), .ctl_o(ctl_o), .fc_o(fc_o), .shared_sram_strobe_n_o(shared_sram_strobe_n_o),
    .addr_ctl_ack_oe_o(addr_ctl_ack_oe_o));

// ==== testbench/dvg_bus_glue_tb.sv ====
`timescale 1ns/1ps
module dvg_bus_glue_tb;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, h1 = 1'b0, h3 = 1'b1, strb_n = 1'b1, go = 1'b0, rw = 1'b1;
    logic h1p = 1'b0, rdp = 1'b1, grp = 1'b1, arm = 1'b0, busy_n, ackl, ackh, berr, lbr, sreq, sstb, sack;
    logic [3:0] st = 4'h0, dly = 4'h0;
    logic [2:0] ad = 3'h0, fc;
    logic [1:0] md = 2'h0, td = 2'h0;
    logic [4:0] dec_o, ctl_o, qd[$], qc[$];
    int bad_count = 0, n_compared = 0, cyc = 0, seed = 32'h4b9808c3;
    dvg_bus_glue DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .dsp_clock_phase1_i(h1), .dsp_clock_phase3_i(h3),
        .gstat_i(st), .gaddr_hi_i(ad), .global_strobe_upper_n_i(strb_n), .gbus_lock_n_i(1'b1), .lbr_n_i(lbr),
        .mst_busy_n_i(busy_n), .deadlock_n_i(1'b1), .size_ack_low_n_i(ackl), .size_ack_high_n_i(ackh),
        .lberr_n_i(berr), .slv_req_n_i(sreq), .slv_rd_wr_i(rw), .slv_size_ok_i(1'b1), .dec_o(dec_o), .ctl_o(ctl_o),
        .fc_o(fc), .shared_sram_strobe_n_o(sstb), .shared_sram_rd_wr_o(), .slv_ack_n_o(sack), .addr_ctl_ack_oe_o());
    dvg_ctl_model u_far (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .fc_i(fc), .lb_grant_n_i(ctl_o[1]), .slv_ack_n_i(sack),
        .go_i(go), .mode_i(md), .dly_i(dly), .mst_busy_n_o(busy_n), .size_ack_low_n_o(ackl),
        .size_ack_high_n_o(ackh), .lberr_n_o(berr), .lbr_n_o(lbr), .slv_req_n_o(sreq));
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp(input logic [4:0] got, input logic [4:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_dec(input logic [4:0] exp); cmp(dec_o, exp); endtask
    task automatic chk_ctl(input logic [4:0] exp); cmp(ctl_o, exp); endtask
    // holds the strobe until ready, as the dsp would; non-decoding cycles just wait out a few phases
    task automatic acc(input logic [3:0] s, input logic [2:0] a, input logic n, input logic [1:0] m,
        input logic [4:0] e);
        int k;
        @(posedge mclk_i);
        st <= s; ad <= a; strb_n <= n; md <= m; dly <= 4'($random(seed));
        qd.push_back(e);
        if (e != 5'h1F) qc.push_back(5'h06);
        k = 0;
        do begin @(negedge mclk_i); k++; end while (e == 5'h1F ? k < 12 : (ctl_o[0] !== 1'b0 && k < 400));
        @(posedge mclk_i);
        strb_n <= 1'b1;
        repeat (12) @(posedge mclk_i);
        $display("access %h at %h done", s, a);
    endtask
    task automatic slave();
        int k;
        @(posedge mclk_i);
        go <= 1'b1;
        qc.push_back(5'h19);
        k = 0;
        do begin @(negedge mclk_i); k++; end while ((k < 4 || lbr !== 1'b1) && k < 400);
        @(posedge mclk_i);
        go <= 1'b0;
        repeat (12) @(posedge mclk_i);
        $display("slave access done");
    endtask
    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        h1 <= cyc[1];
        h3 <= ~cyc[1];
        rw <= 1'($random(seed));
        if (cyc > 20000) begin
            bad_count++;
            conclude();
        end
    end
    // results are taken off settled outputs half a cycle after each edge
    always @(negedge mclk_i) begin
        h1p <= h1;
        rdp <= ctl_o[0];
        grp <= ctl_o[1];
        if (h1 && !h1p) begin
            td <= 2'h3;
            arm <= qd.size() > 0;
        end else if (td != 2'h0) td <= td - 2'h1;
        if (td == 2'h1 && arm) chk_dec(qd.pop_front());
        if (((rdp && !ctl_o[0]) || (grp && !ctl_o[1])) && qc.size() > 0) chk_ctl(qc.pop_front());
    end
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        acc({2'h2, 2'($random(seed))}, 3'h5, 1'b0, 2'h0, 5'h17);
        acc(4'hD, 3'h5, 1'b0, 2'h0, 5'h0F);
        acc(4'hE, 3'h5, 1'b0, 2'h2, 5'h0F);
        acc({2'h2, 2'($random(seed))}, 3'h7, 1'b0, 2'h1, 5'h1D);
        acc(4'hE, 3'h7, 1'b0, 2'h0, 5'h1B);
        acc({2'h2, 2'($random(seed))}, 3'h4, 1'b0, 2'h0, 5'h1E);
        acc(4'h9, 3'h0, 1'b0, 2'h0, 5'h1F);
        acc(4'hC, 3'h5, 1'b0, 2'h0, 5'h1F);
        acc(4'h9, 3'h5, 1'b1, 2'h0, 5'h1F);
        slave();
        slave();
        acc(4'hD, 3'h7, 1'b0, 2'h1, 5'h1B);
        // software bring-up: register base read, controller set-up writes
        acc(4'h8, 3'h7, 1'b0, 2'h1, 5'h1D);
        acc(4'hD, 3'h7, 1'b0, 2'h0, 5'h1B);
        acc(4'hE, 3'h7, 1'b0, 2'h1, 5'h1B);
        if (qd.size() + qc.size() != 0) bad_count++;
        conclude();
    end
endmodule

// ==== testbench/dvg_ctl_model.sv ====
`timescale 1ns/1ps
module dvg_ctl_model (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] fc_i,
    input wire logic lb_grant_n_i,
    input wire logic slv_ack_n_i,
    input wire logic go_i,
    input wire logic [1:0] mode_i,
    input wire logic [3:0] dly_i,
    output logic mst_busy_n_o,
    output logic size_ack_low_n_o,
    output logic size_ack_high_n_o,
    output logic lberr_n_o,
    output logic lbr_n_o,
    output logic slv_req_n_o
);
    logic [3:0] cnt_q;
    logic ack, done_q, mst;
    assign mst = fc_i == dvg_pkg::FC_SUPER_DATA;
    assign ack = mst && cnt_q == dly_i;
    // released ack lines float back to their pull-up level
    always_ff @(posedge mclk_i) begin
        cnt_q <= (!rst_n_i || !mst) ? 4'h0 : (ack ? cnt_q : cnt_q + 4'h1);
        mst_busy_n_o <= !(rst_n_i && mst);
        size_ack_high_n_o <= !(ack && mode_i != 2'h2);
        size_ack_low_n_o <= !(ack && mode_i == 2'h0);
        lberr_n_o <= !(ack && mode_i == 2'h2);
        done_q <= rst_n_i && go_i && (done_q || !slv_ack_n_i);
        lbr_n_o <= !(rst_n_i && go_i && !done_q);
        slv_req_n_o <= !(rst_n_i && go_i && !done_q && !lb_grant_n_i);
    end
endmodule

// ==== verilog/dvg_bus_glue.sv ====
`timescale 1ns/1ps
module dvg_bus_glue (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic dsp_clock_phase1_i,
    input wire logic dsp_clock_phase3_i,
    input wire logic [3:0] gstat_i,
    input wire logic [2:0] gaddr_hi_i,
    input wire logic global_strobe_upper_n_i,
    input wire logic gbus_lock_n_i,
    input wire logic lbr_n_i,
    input wire logic mst_busy_n_i,
    input wire logic deadlock_n_i,
    input wire logic size_ack_low_n_i,
    input wire logic size_ack_high_n_i,
    input wire logic lberr_n_i,
    input wire logic slv_req_n_i,
    input wire logic slv_rd_wr_i,
    input wire logic slv_size_ok_i,
    output logic [4:0] dec_o,
    output logic [4:0] ctl_o,
    output logic [2:0] fc_o,
    output logic shared_sram_strobe_n_o,
    output logic shared_sram_rd_wr_o,
    output logic slv_ack_n_o,
    output logic addr_ctl_ack_oe_o
);
    dvg_pkg::dvg_state_all_t s_q, s_d;
    logic ph1_rise, ph3_rise, rd_stat, wr_stat;
    logic [3:0] nib;

    // ------------------------------------------------------------
    // combinational next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ph1_q = dsp_clock_phase1_i;
        s_d.ph3_q = dsp_clock_phase3_i;
        ph1_rise = dsp_clock_phase1_i & ~s_q.ph1_q;
        ph3_rise = dsp_clock_phase3_i & ~s_q.ph3_q;
        nib = {1'b1, gaddr_hi_i};
        rd_stat = (gstat_i[3:2] == dvg_pkg::STAT_RD_HI);
        wr_stat = (gstat_i == dvg_pkg::STAT_WR_A) || (gstat_i == dvg_pkg::STAT_WR_B);
        if (ph1_rise) begin
            // sram (nib 8) and unused segments fall through with no output
            s_d.dec.mst_rd_n = ~(nib == dvg_pkg::NIB_VME && rd_stat && !global_strobe_upper_n_i);
            s_d.dec.mst_wr_n = ~(nib == dvg_pkg::NIB_VME && wr_stat && !global_strobe_upper_n_i);
            s_d.dec.reg_rd_n = ~(nib == dvg_pkg::NIB_REGS && rd_stat && !global_strobe_upper_n_i);
            s_d.dec.reg_wr_n = ~(nib == dvg_pkg::NIB_REGS && wr_stat && !global_strobe_upper_n_i);
            s_d.dec.boot_rom_read_sel_n = ~(nib == dvg_pkg::NIB_ROM && rd_stat && !global_strobe_upper_n_i);
        end
        if (ph3_rise) begin
            case (s_q.st)
                dvg_pkg::DVG_IDLE: begin
                    // idle: global and master enabled, slave and grant off, ready high
                    s_d.ctl = '{gbus_en_n: 1'b0, mst_oe_n: 1'b0, slv_oe_n: 1'b1,
                                lb_grant_n: 1'b1, dsp_ready_out_n: 1'b1};
                    if (!s_q.dec.mst_rd_n || (!s_q.dec.mst_wr_n && lbr_n_i)) begin
                        s_d.st = dvg_pkg::DVG_MST_ARM;
                    end else if (!s_q.dec.reg_rd_n || (!s_q.dec.reg_wr_n && lbr_n_i)) begin
                        s_d.st = dvg_pkg::DVG_REG_WAIT;
                    end else if (!s_q.dec.boot_rom_read_sel_n && lbr_n_i) begin
                        s_d.st = dvg_pkg::DVG_ROM_WAIT;
                        s_d.cnt = '0;
                    end else if (!lbr_n_i || !deadlock_n_i) begin
                        s_d.ctl.gbus_en_n = 1'b1;
                        s_d.ctl.mst_oe_n = 1'b1;
                        s_d.st = dvg_pkg::DVG_SLV_SEIZE;
                    end
                end
                dvg_pkg::DVG_MST_ARM, dvg_pkg::DVG_MST_WAIT: begin
                    if (!deadlock_n_i) begin
                        s_d.ctl.gbus_en_n = 1'b1;
                        s_d.ctl.mst_oe_n = 1'b1;
                        s_d.st = dvg_pkg::DVG_SLV_SEIZE;
                    end else if (s_q.st == dvg_pkg::DVG_MST_ARM) begin
                        if (!mst_busy_n_i) s_d.st = dvg_pkg::DVG_MST_WAIT;
                    end else if ((!size_ack_high_n_i && !size_ack_low_n_i) || !lberr_n_i) begin
                        s_d.ctl.dsp_ready_out_n = 1'b0;
                        s_d.st = dvg_pkg::DVG_RDY;
                    end
                end
                dvg_pkg::DVG_REG_WAIT: begin
                    if (!size_ack_high_n_i) begin
                        s_d.ctl.dsp_ready_out_n = 1'b0;
                        s_d.st = dvg_pkg::DVG_RDY;
                    end
                end
                dvg_pkg::DVG_ROM_WAIT: begin
                    s_d.cnt = 5'(s_q.cnt + 5'h01);
                    if (s_q.cnt == dvg_pkg::ROM_WAIT_LAST) begin
                        s_d.ctl.dsp_ready_out_n = 1'b0;
                        s_d.st = dvg_pkg::DVG_RDY;
                    end
                end
                dvg_pkg::DVG_RDY: begin
                    s_d.ctl.dsp_ready_out_n = 1'b1;
                    s_d.st = dvg_pkg::DVG_IDLE;
                end
                dvg_pkg::DVG_SLV_SEIZE: begin
                    if (s_q.ctl.slv_oe_n) begin
                        s_d.ctl.slv_oe_n = 1'b0;
                    end else begin
                        s_d.ctl.lb_grant_n = 1'b0;
                        s_d.st = dvg_pkg::DVG_SLV_GRANT;
                    end
                end
                dvg_pkg::DVG_SLV_GRANT: begin
                    if (lbr_n_i && deadlock_n_i) begin
                        s_d.ctl.lb_grant_n = 1'b1;
                        s_d.ctl.slv_oe_n = 1'b1;
                        s_d.st = dvg_pkg::DVG_IDLE;
                    end
                end
                default: s_d.st = dvg_pkg::DVG_IDLE;
            endcase
        end
        // function code driven while the master side is enabled outside idle: master, register, rom and ready states
        s_d.fc = (!s_d.ctl.mst_oe_n && s_d.st != dvg_pkg::DVG_IDLE) ? dvg_pkg::FC_SUPER_DATA : 3'h0;
        // lock input is accepted but never starts a locked sequence on its own
        if (!gbus_lock_n_i && s_q.st == dvg_pkg::DVG_IDLE) s_d.fc = s_d.fc;
        // slave sram access only while granted and size is right
        s_d.slv_strobe_n = ~(!s_q.ctl.lb_grant_n && !slv_req_n_i && slv_size_ok_i);
        s_d.slv_rd_wr = s_q.ctl.lb_grant_n ? 1'b1 : slv_rd_wr_i;
        s_d.slv_ack_n = s_q.slv_strobe_n | slv_req_n_i;
        if (!rst_n_i) begin
            s_d.dec = '1;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_q <= '{dec: 5'h1F, ctl: '{gbus_en_n: 1'b0, mst_oe_n: 1'b0, slv_oe_n: 1'b1,
                     lb_grant_n: 1'b1, dsp_ready_out_n: 1'b1},
                     st: dvg_pkg::DVG_IDLE, cnt: 5'h00, ph1_q: 1'b0, ph3_q: 1'b0,
                     fc: 3'h0, slv_strobe_n: 1'b1, slv_rd_wr: 1'b1, slv_ack_n: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign dec_o = s_q.dec;
    assign ctl_o = s_q.ctl;
    assign fc_o = s_q.fc;
    assign shared_sram_strobe_n_o = s_q.slv_strobe_n;
    assign shared_sram_rd_wr_o = s_q.slv_rd_wr;
    assign slv_ack_n_o = s_q.slv_ack_n; // drives both size acks on the slave side
    assign addr_ctl_ack_oe_o = s_q.ctl.lb_grant_n; // low disables controller acks
endmodule
